// ===== core/qup_top.sv
`timescale 1ns/1ps
module qup_top
  import qup_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic reset_pin,
  input wire logic mode_intel,
  input wire logic irq_output_force,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic [NCH-1:0] cs_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [NCH-1:0] irq_cond,
  input wire logic [NCH-1:0] tx_serial,
  input wire logic [NCH-1:0] tx_enable,
  input wire logic music_clock_in,
  input wire logic music_clock_present,
  input wire logic rx_in_ch3,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic [NCH-1:0] irq_out,
  output logic [NCH-1:0] irq_oe,
  output logic irq_comb_out,
  output logic irq_comb_oe,
  output logic [NCH-1:0] infrared_tx_out,
  output logic [NCH-1:0] modem_tx_out,
  output logic tx_out_ch3,
  output logic rx_ch3_data,
  output logic uart_in_reset
);
  // ------------------------------------------------------------
  // Reset release and pin synchronisers.
  // ------------------------------------------------------------
  logic rs1_q;
  logic rs2_q;
  logic rst_n;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end
    else
    begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_n = rs2_q;

  localparam int SW = 19 + 4 * NCH;
  logic [SW-1:0] s_raw;
  logic [SW-1:0] s_q;
  assign s_raw = {reset_pin, mode_intel, irq_output_force, rd_strobe_n, wr_strobe_n,
                  music_clock_in, music_clock_present, rx_in_ch3, addr, data_in, cs_n,
                  irq_cond, tx_serial, tx_enable};
  qup_sync #(.W(SW)) u_sync (.mclk(mclk), .rst_n(rst_n), .d(s_raw), .q(s_q));

  logic rp_s, intel_s, force_s, rd_s, wr_s, mclk_s, mpres_s, rx3_s;
  logic [2:0] addr_s;
  logic [7:0] data_s;
  logic [NCH-1:0] cs_s, cond_s, txs_s, txe_s;
  assign {rp_s, intel_s, force_s, rd_s, wr_s, mclk_s, mpres_s, rx3_s, addr_s, data_s, cs_s,
          cond_s, txs_s, txe_s} = s_q;

  // ------------------------------------------------------------
  // Device reset follows the bus mode polarity.
  // ------------------------------------------------------------
  logic dev_rst;
  assign dev_rst = intel_s ? rp_s : !rp_s;

  // ------------------------------------------------------------
  // Strobe decode and register file.
  // ------------------------------------------------------------
  logic rd_n_q, rd_n_d, wr_n_q, wr_n_d;
  logic rd_evt, wr_evt, rd_act;
  qup_chan_t [NCH-1:0] ch_q;
  qup_chan_t [NCH-1:0] ch_d;
  logic [7:0] dout_q, dout_d;
  logic doe_q, doe_d;
  logic [7:0] rd_mux;
  logic [1:0] sel;
  logic sel_ok;

  always_comb
  begin
    rd_n_d = rd_s;
    wr_n_d = wr_s;
    sel = 2'h0;
    sel_ok = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      if (!cs_s[i] && !sel_ok)
      begin
        sel = 2'(i);
        sel_ok = 1'b1;
      end
    end
    // In the alternative mode the write pin is the read/write select,
    // high for read; the read strobe pin is the data strobe.
    if (intel_s)
    begin
      rd_evt = rd_n_q && !rd_s;
      wr_evt = wr_n_q && !wr_s;
      rd_act = !rd_s;
    end
    else
    begin
      rd_evt = !rd_n_q && rd_s && wr_s;
      wr_evt = rd_n_q && !rd_s && !wr_s;
      rd_act = wr_s && !rd_s;
    end
    rd_evt = rd_evt && sel_ok;
    wr_evt = wr_evt && sel_ok;
    unique case (addr_s)
      ADDR_IER: rd_mux = ch_q[sel].irq_enable_reg;
      ADDR_ISR: rd_mux = (cond_s[sel] && ch_q[sel].irq_enable_reg != 8'h00) ? 8'h00 : ISR_NONE;
      ADDR_LCR: rd_mux = ch_q[sel].lcr;
      ADDR_SCR: rd_mux = ch_q[sel].scr;
      default: rd_mux = 8'h00;
    endcase
    ch_d = ch_q;
    if (wr_evt)
    begin
      unique case (addr_s)
        ADDR_IER: ch_d[sel].irq_enable_reg = data_s;
        ADDR_LCR: ch_d[sel].lcr = data_s;
        ADDR_SCR: ch_d[sel].scr = data_s;
        default: ch_d[sel].scr = ch_q[sel].scr;
      endcase
    end
    dout_d = rd_evt ? rd_mux : dout_q;
    doe_d = rd_act && sel_ok;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      dout_q <= 8'h00;
      doe_q <= 1'b0;
      for (int i = 0; i < NCH; i++)
      begin
        ch_q[i] <= '{lcr: LCR_RESET, irq_enable_reg: IER_RESET, scr: 8'h00};
      end
    end
    else if (dev_rst)
    begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      dout_q <= 8'h00;
      doe_q <= 1'b0;
      for (int i = 0; i < NCH; i++)
      begin
        ch_q[i] <= '{lcr: LCR_RESET, irq_enable_reg: IER_RESET, scr: 8'h00};
      end
    end
    else
    begin
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      ch_q <= ch_d;
    end
  end
  assign data_out = dout_q;
  assign data_oe = doe_q;

  // ------------------------------------------------------------
  // Interrupt and serial output stage.
  // ------------------------------------------------------------
  logic [NCH-1:0] irq_q, irq_d, ioe_q, ioe_d, irt_q, irt_d, mtx_q, mtx_d;
  logic ic_oe_q, ic_oe_d, tx3_q, tx3_d, rx3_q, rx3_d, urst_q, urst_d;
  logic [NCH-1:0] pend;
  logic [NCH-1:0] lcr_en;

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    assign lcr_en[g] = ch_q[g].lcr[LCR_IRQ_EN_BIT];
    always_comb
    begin
      pend[g] = cond_s[g] && (ch_q[g].irq_enable_reg != 8'h00);
      if (force_s && intel_s)
        ioe_d[g] = 1'b1;
      else
        ioe_d[g] = intel_s && ch_q[g].lcr[LCR_IRQ_EN_BIT];
      irq_d[g] = ioe_d[g] && pend[g];
      if (txe_s[g] && ch_q[g].lcr[LCR_IR_SEL_BIT])
      begin
        irt_d[g] = !txs_s[g];
        mtx_d[g] = 1'b1;
      end
      else
      begin
        irt_d[g] = 1'b0;
        mtx_d[g] = txe_s[g] ? txs_s[g] : 1'b1;
      end
    end
  end

  always_comb
  begin
    ic_oe_d = !intel_s && (|pend);
    tx3_d = mpres_s ? mclk_s & mtx_d[2] : mtx_d[2];
    rx3_d = rx3_s;
    urst_d = dev_rst;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= '0;
      ioe_q <= '0;
      irt_q <= '0;
      mtx_q <= '1;
      ic_oe_q <= 1'b0;
      tx3_q <= 1'b1;
      rx3_q <= 1'b1;
      urst_q <= 1'b1;
    end
    else if (dev_rst)
    begin
      irq_q <= '0;
      ioe_q <= '0;
      irt_q <= '0;
      mtx_q <= '1;
      ic_oe_q <= 1'b0;
      tx3_q <= 1'b1;
      rx3_q <= 1'b1;
      urst_q <= 1'b1;
    end
    else
    begin
      irq_q <= irq_d;
      ioe_q <= ioe_d;
      irt_q <= irt_d;
      mtx_q <= mtx_d;
      ic_oe_q <= ic_oe_d;
      tx3_q <= tx3_d;
      rx3_q <= rx3_d;
      urst_q <= urst_d;
    end
  end
  assign irq_out = irq_q;
  assign irq_oe = ioe_q;
  assign irq_comb_out = 1'b0;
  assign irq_comb_oe = ic_oe_q;
  assign infrared_tx_out = irt_q;
  assign modem_tx_out = mtx_q;
  assign tx_out_ch3 = tx3_q;
  assign rx_ch3_data = rx3_q;
  assign uart_in_reset = urst_q;

  // ------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------
  a_force_drives: assert property (@(posedge mclk) disable iff (!rst_n)
    (intel_s && force_s && !dev_rst) |=> (irq_oe == '1))
    else $error("forced interrupts not driven");
  a_lcr_enable: assert property (@(posedge mclk) disable iff (!rst_n)
    (intel_s && !force_s && !dev_rst) |=> (irq_oe == $past(lcr_en)))
    else $error("interrupt enable mismatch");
  a_alt_no_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    (!intel_s) |=> (irq_oe == '0))
    else $error("channel interrupts driven in alternative mode");
  a_float_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (irq_out & ~irq_oe) == '0)
    else $error("undriven interrupt high");
  a_read_data: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_evt && !dev_rst) |=> (data_out == $past(rd_mux)))
    else $error("read data wrong");
  a_write_load: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_evt && !dev_rst && addr_s == ADDR_SCR) |=> (ch_q[$past(sel)].scr == $past(data_s)))
    else $error("write not loaded");
  a_comb_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    (!intel_s && (|pend) && !dev_rst) |=> irq_comb_oe)
    else $error("combined request not asserted");
  a_comb_low: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_comb_out == 1'b0)
    else $error("combined request drives high");
  a_ir_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    dev_rst |=> (infrared_tx_out == '0 && uart_in_reset))
    else $error("infrared not low in reset");
  a_reset_serial: assert property (@(posedge mclk) disable iff (!rst_n)
    dev_rst |=> (modem_tx_out == '1 && rx_ch3_data && tx_out_ch3))
    else $error("serial pins not idle in reset");
endmodule

// ===== inc/qup_pkg.sv
package qup_pkg;
  localparam int NCH = 4;
  localparam int LCR_IRQ_EN_BIT = 3;
  localparam int LCR_IR_SEL_BIT = 6;
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_ISR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h4;
  localparam logic [2:0] ADDR_SCR = 3'h7;
  localparam logic [7:0] ISR_NONE = 8'h01;
  typedef struct packed {
    logic [7:0] lcr;
    logic [7:0] irq_enable_reg;
    logic [7:0] scr;
  } qup_chan_t;
  typedef enum logic [1:0] {
    QUP_IDLE = 2'b00,
    QUP_RD = 2'b01,
    QUP_WR = 2'b10
  } qup_state_t;
endpackage

// ===== core/qup_sync.sv
`timescale 1ns/1ps
module qup_sync
  import qup_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule

// ===== tb/qup_host.sv
`timescale 1ns/1ps
module qup_host
  import qup_pkg::*;
(
  input wire logic mclk,
  output logic rd_strobe_n,
  output logic wr_strobe_n,
  output logic [NCH-1:0] cs_n,
  output logic [2:0] addr,
  output logic [7:0] data_in
);
  // ----------------
  // Host bus cycles
  // ----------------
  initial
  begin
    rd_strobe_n = 1'b1;
    wr_strobe_n = 1'b1;
    cs_n = 4'hF;
    addr = 3'h0;
    data_in = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input int c, input logic [2:0] a, input logic [7:0] d);
    cs_n = ~(4'h1 << c);
    addr = a;
    data_in = d;
    wr_strobe_n = 1'b0;
    cyc(4);
    wr_strobe_n = 1'b1;
    cs_n = 4'hF;
    data_in = ~d;
    cyc(4);
  endtask
  task automatic rd(input int c, input logic [2:0] a);
    cs_n = ~(4'h1 << c);
    addr = a;
    rd_strobe_n = 1'b0;
    cyc(5);
    rd_strobe_n = 1'b1;
    cs_n = 4'hF;
    cyc(4);
  endtask
endmodule

// ===== tb/quad_uart_host_pins_irq_bench.sv
`timescale 1ns/1ps
module quad_uart_host_pins_irq_bench
  import qup_pkg::*;
;
  logic mclk, rstn, reset_pin, mode_intel, irq_output_force, rd_n, wr_n;
  logic music_clk, music_on, rx3, tx3, rx3_out;
  logic [3:0] modem_tx;
  logic [3:0] cs_n, irq_cond, tx_serial, tx_enable, irq_out, irq_oe, ir_out;
  logic [2:0] addr;
  logic [7:0] din, data_out;
  logic data_oe, comb_out, comb_oe, in_rst, oe_prev;
  logic [31:0] r;
  logic [7:0] sv[4];
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  qup_host qup_host_i (.mclk(mclk), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n),
    .cs_n(cs_n), .addr(addr), .data_in(din));
  qup_top qup_top_i (.mclk(mclk), .rstn(rstn), .reset_pin(reset_pin),
    .mode_intel(mode_intel), .irq_output_force(irq_output_force),
    .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .cs_n(cs_n), .addr(addr),
    .data_in(din), .irq_cond(irq_cond), .tx_serial(tx_serial),
    .tx_enable(tx_enable), .music_clock_in(music_clk), .music_clock_present(music_on),
    .rx_in_ch3(rx3), .data_out(data_out), .data_oe(data_oe), .irq_out(irq_out),
    .irq_oe(irq_oe), .irq_comb_out(comb_out), .irq_comb_oe(comb_oe),
    .infrared_tx_out(ir_out), .modem_tx_out(modem_tx), .tx_out_ch3(tx3),
    .rx_ch3_data(rx3_out),
    .uart_in_reset(in_rst));
  // ----------------
  // Checking
  // ----------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic rd(input int c, input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    qup_host_i.rd(c, a);
  endtask
  task automatic irqs(input logic [7:0] e);
    qup_host_i.cyc(4);
    check({irq_out, irq_oe}, e);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  initial oe_prev = 1'b0;
  always @(posedge mclk)
  begin
    if (data_oe === 1'b1 && oe_prev !== 1'b1)
      check(data_out, exp_q.pop_front());
    oe_prev <= data_oe;
  end
  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    rstn = 1'b0;
    reset_pin = 1'b0;
    mode_intel = 1'b1;
    irq_output_force = 1'b0;
    irq_cond = 4'h0;
    tx_serial = 4'h0;
    tx_enable = 4'h0;
    music_clk = 1'b0;
    music_on = 1'b0;
    rx3 = 1'b0;
    r = $urandom(99);
    repeat (3) @(posedge mclk);
    #1 rstn = 1'b1;
    qup_host_i.cyc(4);
    for (int c = 0; c < NCH; c++)
    begin
      rd(c, ADDR_LCR, LCR_RESET);
      rd(c, ADDR_IER, IER_RESET);
      rd(c, ADDR_ISR, ISR_NONE);
      rd(c, 3'h0, 8'h00);
      r = $urandom;
      sv[c] = r[7:0];
      qup_host_i.wr(c, ADDR_SCR, sv[c]);
    end
    for (int c = 0; c < NCH; c++)
      rd(c, ADDR_SCR, sv[c]);
    qup_host_i.wr(0, ADDR_ISR, 8'h00);
    rd(0, ADDR_ISR, ISR_NONE);
    for (int c = 0; c < NCH; c++)
      qup_host_i.wr(c, ADDR_LCR, 8'h40);
    tx_enable = 4'hF;
    tx_serial = r[11:8];
    qup_host_i.cyc(4);
    check({4'h0, ir_out}, {4'h0, ~r[11:8]});
    tx_enable = 4'h3;
    qup_host_i.cyc(4);
    check({4'h0, ir_out}, {4'h0, ~r[11:8] & 4'h3});
    for (int c = 0; c < NCH; c++)
      qup_host_i.wr(c, ADDR_IER, 8'h0F);
    irq_cond = 4'h6;
    irq_output_force = 1'b1;
    irqs(8'h6F);
    irq_output_force = 1'b0;
    irqs(8'h00);
    qup_host_i.wr(1, ADDR_LCR, 8'h08);
    irqs(8'h22);
    rd(2, ADDR_ISR, 8'h00);
    mode_intel = 1'b0;
    reset_pin = 1'b1;
    irq_output_force = 1'b1;
    irqs(8'h00);
    check({6'h0, comb_oe, comb_out}, 8'h02);
    irq_cond = 4'h0;
    qup_host_i.cyc(4);
    check({6'h0, comb_oe, comb_out}, 8'h00);
    reset_pin = 1'b0;
    qup_host_i.cyc(4);
    check({7'h0, in_rst}, 8'h01);
    reset_pin = 1'b1;
    qup_host_i.cyc(2);
    mode_intel = 1'b1;
    reset_pin = 1'b0;
    irq_output_force = 1'b0;
    irq_cond = 4'h6;
    irqs(8'h00);
    rd(1, ADDR_LCR, LCR_RESET);
    qup_host_i.wr(3, ADDR_SCR, 8'hA5);
    reset_pin = 1'b1;
    qup_host_i.cyc(4);
    check({3'h0, in_rst, ir_out}, 8'h10);
    check({modem_tx, 2'h0, tx3, rx3_out}, 8'hF3);
    reset_pin = 1'b0;
    qup_host_i.cyc(4);
    rd(3, ADDR_SCR, 8'h00);
    r = $urandom;
    tx_enable = 4'hF;
    tx_serial = r[3:0];
    rx3 = r[4];
    music_on = 1'b1;
    music_clk = 1'b1;
    qup_host_i.cyc(4);
    check({ir_out, modem_tx}, {4'h0, r[3:0]});
    check({6'h0, tx3, rx3_out}, {6'h0, r[2], r[4]});
    music_clk = 1'b0;
    qup_host_i.cyc(4);
    check({6'h0, tx3, rx3_out}, {6'h0, 1'b0, r[4]});
    music_on = 1'b0;
    qup_host_i.cyc(4);
    check({7'h0, tx3}, {7'h0, r[2]});
    check(8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule
